// ---- logic/stcc_defs.vh ----
// constants for the smoke test and calibration control block
`ifndef STCC_DEFS_VH
`define STCC_DEFS_VH
`define STCC_CLK_NS 8
`define STCC_OSC_PERIOD_US 10500
`define STCC_TEST_PULSE_MS 336
`define STCC_OSC_CYC ((`STCC_OSC_PERIOD_US * 1000) / `STCC_CLK_NS)
`define STCC_TEST_OSC_CNT ((`STCC_TEST_PULSE_MS * 1000) / `STCC_OSC_PERIOD_US)
`define STCC_MODE_STANDBY 2'h0
`define STCC_MODE_TEST 2'h1
`define STCC_MODE_CAL 2'h2
`define STCC_RELEASE_PULSES 2'h2
`endif

// ---- logic/stcc_ctrl.v ----
// test and calibration mode control for a photoelectric smoke detector
//
// Operation
// [R01] a high test input enters manual test mode
// [R02] one oscillator cycle into test, fire emitter every 336 ms regardless of smoke; code fires the first pulse 32 oscillator cycles (336 ms) into test
// [R03] test mode selects the high gain capacitor to simulate smoke
// [R04] smoke on second test pulse drives horn and interconnect
// [R05] one oscillator cycle after test release, restore normal gain
// [R06] after gain restored, two more pulses end alarm, then standby timing
// [R07] fixture pulls test below ground for one oscillator cycle to enter calibration
// [R08] fixture floats test for one oscillator cycle to leave calibration
// [R09] calibration fires emitter every clock and holds strobe low
// [R10] calibration suppresses low battery and chamber sensitivity checks
// [R11] calibration stops driving interconnect; forced high routes amp pulses to guard
// [R12] supply trip low: normal gain guard one; high: supervisory gain guard two
// [R13] feedback high adds hysteresis only while supply trip low
// [R14] calibration internal clock follows oscillator pin level
// [R15] first horn pin shows raw comparator result in calibration
// [R16] second horn pin shows two-in-a-row smoke integrator in calibration
// [R17] timing derives from a 10.5 ms oscillator period
// [R18] mode changes only after the condition lasts a full oscillator cycle
// [R19] calibration wins over manual test
`timescale 1ns/1ps
`default_nettype none
`include "stcc_defs.vh"
module stcc_ctrl #(
  parameter [31:0] OSC_CYC = `STCC_OSC_CYC
) (
  input wire clk,
  input wire reset_n,
  input wire testHigh,
  input wire testBelowGnd,
  input wire testFloat,
  input wire oscPin,
  input wire smokeDetect,
  input wire ampPulse,
  input wire normalAlarm,
  input wire ioIn,
  input wire supplyTrip,
  input wire feedbackIn,
  output reg infrared_emitter_pulse,
  output reg strobe_n,
  output reg high_gain_capacitor,
  output reg supervisoryGain,
  output reg hysteresisEn,
  output reg hornOn,
  output reg ioOut,
  output reg ioOe_n,
  output reg guard1Out,
  output reg guard2Out,
  output reg hornPin1,
  output reg hornPin2,
  output reg lowBattCheckEn,
  output reg chamberCheckEn,
  output reg intClk,
  output reg [1:0] modeOut
);
  reg rst1_ff, rstS_ff;
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst1_ff <= 1'b0;
      rstS_ff <= 1'b0;
    end
    else
    begin
      rst1_ff <= 1'b1;
      rstS_ff <= rst1_ff;
    end
  end
  wire rstN = rstS_ff;
  // oscillator tick from divider
  reg [31:0] oscCnt_ff;
  wire oscTick = (oscCnt_ff == OSC_CYC - 32'h1); // [R17]
  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      oscCnt_ff <= 32'h0;
    else if (oscTick)
      oscCnt_ff <= 32'h0;
    else
      oscCnt_ff <= oscCnt_ff + 32'h1;
  end
  // persistence over one full oscillator cycle
  reg belowSeen_ff, floatSeen_ff, highSeen_ff, lowSeen_ff;
  reg [1:0] mode_ff;
  reg gainHigh_ff, alarm_ff, firstPulseSeen_ff;
  reg [1:0] relCnt_ff;
  reg [5:0] pulseCnt_ff;
  reg integ_ff, lastDet_ff;
  reg [1:0] nxt_mode;
  always @*
  begin
    nxt_mode = mode_ff;
    if (mode_ff == `STCC_MODE_CAL)
    begin
      if (floatSeen_ff && testFloat)
        nxt_mode = `STCC_MODE_STANDBY; // [R08]
    end
    else if (belowSeen_ff && testBelowGnd)
      nxt_mode = `STCC_MODE_CAL; // [R07] [R19]
    else if (mode_ff == `STCC_MODE_STANDBY && highSeen_ff && testHigh)
      nxt_mode = `STCC_MODE_TEST; // [R01] [R18]
    else if (mode_ff == `STCC_MODE_TEST && !gainHigh_ff && !alarm_ff && lowSeen_ff && !testHigh)
      nxt_mode = `STCC_MODE_STANDBY; // [R06]
  end
  wire inCal = (mode_ff == `STCC_MODE_CAL);
  wire inTest = (mode_ff == `STCC_MODE_TEST);
  wire testPulse = inTest && oscTick &&
    (pulseCnt_ff == `STCC_TEST_OSC_CNT - 1); // [R02]
  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      belowSeen_ff <= 1'b0;
      floatSeen_ff <= 1'b0;
      highSeen_ff <= 1'b0;
      lowSeen_ff <= 1'b0;
      mode_ff <= `STCC_MODE_STANDBY;
      gainHigh_ff <= 1'b0;
      alarm_ff <= 1'b0;
      firstPulseSeen_ff <= 1'b0;
      relCnt_ff <= 2'h0;
      pulseCnt_ff <= 6'h0;
      integ_ff <= 1'b0;
      lastDet_ff <= 1'b0;
    end
    else
    begin
      if (oscTick)
      begin
        // sample held for a whole oscillator cycle
        belowSeen_ff <= testBelowGnd; // [R18]
        floatSeen_ff <= testFloat;
        highSeen_ff <= testHigh;
        lowSeen_ff <= !testHigh;
        mode_ff <= nxt_mode;
      end
      if (oscTick && inTest)
        pulseCnt_ff <= testPulse ? 6'h0 : pulseCnt_ff + 6'h1;
      else if (!inTest)
        pulseCnt_ff <= 6'h0;
      if (oscTick && inTest && highSeen_ff && testHigh)
        gainHigh_ff <= 1'b1; // [R03]
      else if (oscTick && lowSeen_ff && !testHigh && gainHigh_ff)
      begin
        gainHigh_ff <= 1'b0; // [R05]
        relCnt_ff <= 2'h0;
      end
      else if (!inTest)
        gainHigh_ff <= 1'b0;
      if (!inTest)
      begin
        alarm_ff <= 1'b0;
        firstPulseSeen_ff <= 1'b0;
      end
      else if (testPulse)
      begin
        if (gainHigh_ff)
        begin
          if (firstPulseSeen_ff && smokeDetect)
            alarm_ff <= 1'b1; // [R04]
          firstPulseSeen_ff <= 1'b1;
        end
        else if (alarm_ff)
        begin
          relCnt_ff <= relCnt_ff + 2'h1;
          if (relCnt_ff + 2'h1 == `STCC_RELEASE_PULSES)
            alarm_ff <= 1'b0; // [R06]
        end
      end
      if (inCal && oscTick)
      begin
        lastDet_ff <= smokeDetect;
        if (smokeDetect && lastDet_ff)
          integ_ff <= 1'b1; // [R16]
        else if (!smokeDetect && !lastDet_ff)
          integ_ff <= 1'b0;
      end
    end
  end
  // output register
  wire ioHigh = inCal && ioIn;
  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      infrared_emitter_pulse <= 1'b0;
      strobe_n <= 1'b1;
      high_gain_capacitor <= 1'b0;
      supervisoryGain <= 1'b0;
      hysteresisEn <= 1'b0;
      hornOn <= 1'b0;
      ioOut <= 1'b0;
      ioOe_n <= 1'b1;
      guard1Out <= 1'b0;
      guard2Out <= 1'b0;
      hornPin1 <= 1'b0;
      hornPin2 <= 1'b0;
      lowBattCheckEn <= 1'b1;
      chamberCheckEn <= 1'b1;
      intClk <= 1'b0;
      modeOut <= `STCC_MODE_STANDBY;
    end
    else
    begin
      modeOut <= mode_ff;
      infrared_emitter_pulse <= inCal ? 1'b1 : testPulse; // [R09] [R02]
      strobe_n <= !inCal; // [R09]
      high_gain_capacitor <= inTest && gainHigh_ff; // [R03]
      supervisoryGain <= ioHigh && supplyTrip; // [R12]
      hysteresisEn <= inCal && feedbackIn && !supplyTrip; // [R13]
      hornOn <= !inCal && ((inTest && alarm_ff) || normalAlarm); // [R04]
      ioOut <= !inCal && ((inTest && alarm_ff) || normalAlarm);
      ioOe_n <= inCal ? 1'b1 : !((inTest && alarm_ff) || normalAlarm); // [R11]
      guard1Out <= ioHigh && !supplyTrip && ampPulse; // [R11] [R12]
      guard2Out <= ioHigh && supplyTrip && ampPulse; // [R12]
      hornPin1 <= inCal && smokeDetect; // [R15]
      hornPin2 <= inCal && integ_ff; // [R16]
      lowBattCheckEn <= !inCal; // [R10]
      chamberCheckEn <= !inCal; // [R10]
      intClk <= inCal ? oscPin : (oscCnt_ff < (OSC_CYC >> 1)); // [R14]
    end
  end
endmodule // stcc_ctrl
`default_nettype wire

// ---- test/stcc_fixture.sv ----
// push button and calibration fixture on the test pin
`timescale 1ns/1ps
`default_nettype none
module stcc_fixture (
  input wire logic [1:0] cmd,
  output wire logic testHigh,
  output wire logic testBelowGnd,
  output wire logic testFloat
);
  // 0 released to pull-down, 1 pressed, 2 pulled below ground, 3 floated
  assign testHigh = cmd == 2'h1;
  assign testBelowGnd = cmd == 2'h2;
  assign testFloat = cmd == 2'h3;
endmodule // stcc_fixture
`default_nettype wire

// ---- test/stcc_ctrl_monitor.sv ----
// assertions on the test and calibration control ports
`timescale 1ns/1ps
`default_nettype none
module stcc_ctrl_monitor #(
  parameter [31:0] OSC_CYC = 8
) (
  input wire clk,
  input wire reset_n,
  input wire testHigh,
  input wire ioIn,
  input wire supplyTrip,
  input wire infrared_emitter_pulse,
  input wire strobe_n,
  input wire high_gain_capacitor,
  input wire hysteresisEn,
  input wire ioOe_n,
  input wire guard2Out,
  input wire lowBattCheckEn,
  input wire chamberCheckEn,
  input wire [1:0] modeOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire calMode = modeOut == 2'h2;
  sequence sCalHeld; calMode [*2]; endsequence
  sequence sTestEntry; $rose(modeOut == 2'h1); endsequence
  a_cal_emit_on: assert property (sCalHeld |-> infrared_emitter_pulse)
    else $error("emitter idle in calibration");
  a_cal_strobe_low: assert property (sCalHeld |-> !strobe_n)
    else $error("strobe released in calibration");
  a_cal_checks_off: assert property (sCalHeld |-> !lowBattCheckEn && !chamberCheckEn)
    else $error("checks enabled in calibration");
  a_cal_io_released: assert property (sCalHeld |-> ioOe_n)
    else $error("interconnect driven in calibration");
  a_test_gain_high: assert property (sTestEntry |-> ##[0:40] high_gain_capacitor)
    else $error("high gain missing in test");
  a_cal_over_test: assert property (calMode && testHigh |=> calMode)
    else $error("calibration left on button press");
  a_guard_sel_low: assert property ((calMode && ioIn && !supplyTrip) [*8] |=> !guard2Out)
    else $error("second guard active at low trip");
  a_hyst_gate: assert property ((calMode && supplyTrip) [*8] |=> !hysteresisEn)
    else $error("hysteresis with high trip");
endmodule // stcc_ctrl_monitor
bind stcc_ctrl stcc_ctrl_monitor #(.OSC_CYC(OSC_CYC)) mon (.*);
`default_nettype wire

// ---- test/stcc_ctrl_test.sv ----
// self-checking bench for the test and calibration control
`timescale 1ns/1ps
`default_nettype none
module stcc_ctrl_test;
  logic clk = 0, reset_n = 0, oscPin = 0, smokeDetect = 0, ampPulse = 0;
  logic ioIn = 0, supplyTrip = 0, feedbackIn = 0;
  logic [1:0] cmd = 0;
  wire testHigh, testBelowGnd, testFloat, emit, strobe_n, gain, supGain, hyst, hornOn, ioOut;
  wire ioOe_n, g1, g2, hp1, hp2, lbc, ccc, intClk;
  wire [1:0] mode;
  int err_total = 0, check_count = 0, pulses = 0, p0;
  stcc_fixture fix (.cmd(cmd), .testHigh(testHigh), .testBelowGnd(testBelowGnd),
    .testFloat(testFloat));
  stcc_ctrl #(.OSC_CYC(8)) dut (.clk(clk), .reset_n(reset_n), .testHigh(testHigh),
    .testBelowGnd(testBelowGnd), .testFloat(testFloat), .oscPin(oscPin),
    .smokeDetect(smokeDetect), .ampPulse(ampPulse), .normalAlarm(1'b0), .ioIn(ioIn),
    .supplyTrip(supplyTrip), .feedbackIn(feedbackIn), .infrared_emitter_pulse(emit),
    .strobe_n(strobe_n), .high_gain_capacitor(gain), .supervisoryGain(supGain),
    .hysteresisEn(hyst), .hornOn(hornOn), .ioOut(ioOut), .ioOe_n(ioOe_n), .guard1Out(g1),
    .guard2Out(g2), .hornPin1(hp1), .hornPin2(hp2), .lowBattCheckEn(lbc),
    .chamberCheckEn(ccc), .intClk(intClk), .modeOut(mode));
  initial forever #4 clk = ~clk;
  always @(posedge clk) if (emit === 1'b1) pulses++;
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // toggles the oscillator pin so calibration sees clock edges
  task osc(input int n);
    repeat (n)
    begin
      oscPin <= ~oscPin;
      cyc(4);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_total++;
    conclude;
  end
  initial
  begin
    cyc(2);
    chk("reset", {strobe_n, ioOe_n, lbc, ccc, mode}, 8'h3C);
    reset_n <= 1;
    cyc(4);
    cmd <= 2'h1;
    smokeDetect <= 1;
    repeat (40) if (mode !== 2'h1) cyc(1);
    chk("test", mode, 8'h1);
    p0 = pulses;
    repeat (700) if (hornOn !== 1'b1) cyc(1);
    chk("pulses", 8'(pulses - p0), 8'h2);
    chk("alarm", {gain, hornOn, ioOut, ioOe_n}, 8'hE);
    cmd <= 2'h0;
    cyc(2);
    chk("gainhold", gain, 8'h1);
    repeat (40) if (gain !== 1'b0) cyc(1);
    chk("gainlow", gain, 8'h0);
    smokeDetect <= 0;
    p0 = pulses;
    repeat (700) if (hornOn !== 1'b0) cyc(1);
    repeat (40) if (mode !== 2'h0) cyc(1);
    chk("release", {8'(pulses - p0), mode}, 8'h8);
    cmd <= 2'h2;
    ioIn <= 1;
    feedbackIn <= 1;
    ampPulse <= 1;
    repeat (40) if (mode !== 2'h2) cyc(1);
    cyc(2);
    chk("cal", {emit, strobe_n, lbc, ccc, ioOe_n}, 8'h11);
    cmd <= 2'h1;
    osc(6);
    chk("priority", mode, 8'h2);
    cmd <= 2'h2;
    osc(4);
    chk("guardlow", {g1, g2, supGain, hyst}, 8'h9);
    supplyTrip <= 1;
    osc(4);
    chk("guardhigh", {g1, g2, supGain, hyst}, 8'h6);
    osc(1);
    chk("intclk", intClk, {7'h0, oscPin});
    smokeDetect <= 1;
    osc(6);
    chk("integrate", {hp1, hp2}, 8'h3);
    smokeDetect <= 0;
    osc(6);
    chk("nosmoke", {hp1, hp2}, 8'h0);
    cmd <= 2'h3;
    repeat (40) if (mode !== 2'h0) cyc(1);
    chk("exit", mode, 8'h0);
    conclude;
  end
endmodule // stcc_ctrl_test
`default_nettype wire
